// >>> inc/stp_pkg.sv
// Constants, state codes and carrier types for the SRAM test access port
package stp_pkg;

  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 8;
  localparam int SYNC_N = 3;

  localparam logic [IR_W-1:0] IR_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] IR_SAMPZ = 3'h2;
  localparam logic [IR_W-1:0] IR_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;

  // Capture pattern for the instruction shift register, upper bit zero
  localparam logic [IR_W-1:0] IR_CAPT_VAL = 3'h1;

  // Identification word, arbitrary value; bit 0 set as the scan standard asks
  localparam logic [ID_W-1:0] ID_VALUE = 32'h0A5C_3001;

  localparam logic [BSR_W-1:0] BSR_RST = 8'h00;
  localparam logic [SYNC_N-1:0] SYNC_RST = 3'h0;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UP_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UP_IR = 16'h8000
  } stp_state_e;

  // Word handed from the scan side to the core side on a boundary update that finds no earlier word in flight
  typedef struct packed {
    logic samplez;
    logic [BSR_W-1:0] bits;
  } stp_upd_s;

  localparam stp_upd_s UPD_RST = '{samplez: 1'b0, bits: BSR_RST};

  // True when the instruction selects the boundary register
  function automatic logic stp_is_bsr(input logic [IR_W-1:0] ir);
    return (ir == IR_EXTEST) || (ir == IR_SAMPLE) || (ir == IR_SAMPZ);
  endfunction : stp_is_bsr

endpackage : stp_pkg

// >>> rtl/stp_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module stp_buf
  import stp_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input stp_upd_s in_data,
  output logic out_valid,
  input wire logic out_ready,
  output stp_upd_s out_data
);

  // Entry 0 is the head and feeds the outputs directly
  stp_upd_s mem_reg [0:1];
  logic [1:0] vld_reg;
  logic push;
  logic pop;

  assign in_ready = !vld_reg[1];
  assign push = in_valid && in_ready;
  assign pop = vld_reg[0] && out_ready;
  assign out_valid = vld_reg[0];
  assign out_data = mem_reg[0];

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mem_reg[0] <= UPD_RST;
      mem_reg[1] <= UPD_RST;
      vld_reg <= 2'h0;
    end else if (pop && vld_reg[1]) begin
      mem_reg[0] <= mem_reg[1];
      mem_reg[1] <= push ? in_data : mem_reg[1];
      vld_reg <= {push, 1'b1};
    end else if (pop) begin
      mem_reg[0] <= push ? in_data : mem_reg[0];
      vld_reg <= {1'b0, push};
    end else if (push && !vld_reg[0]) begin
      mem_reg[0] <= in_data;
      vld_reg <= 2'h1;
    end else if (push) begin
      mem_reg[1] <= in_data;
      vld_reg <= 2'h3;
    end
  end

endmodule : stp_buf

// >>> rtl/stp_tap.sv
// Boundary-scan test access port with a core-side hand-off of boundary updates
`timescale 1ns/1ps
module stp_tap
  import stp_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic tap_por_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tms_undriven,
  input wire logic tdi,
  input wire logic tdi_undriven,
  output logic tdo,
  output logic tdo_oe_n,
  input wire logic [BSR_W-1:0] pad_in,
  output logic extest_mode,
  output logic samplez_mode,
  output logic upd_valid,
  input wire logic upd_ready,
  output stp_upd_s upd_word
);

  // Scan-side signals, all on the test clock
  stp_state_e state_reg;
  stp_state_e state_next;
  logic tms_eff;
  logic tdi_eff;
  logic [IR_W-1:0] ir_sh_reg;
  logic [IR_W-1:0] ir_reg;
  logic [ID_W-1:0] id_sh_reg;
  logic byp_reg;
  logic [BSR_W-1:0] bsr_sh_reg;
  logic [BSR_W-1:0] pad_s1_reg;
  logic [BSR_W-1:0] pad_s2_reg;
  logic [BSR_W-1:0] pad_s3_reg;
  logic [BSR_W-1:0] pad_flt_reg;
  logic [BSR_W-1:0] pad_diff;
  logic [1:0] mode_src_reg;
  stp_upd_s hold_reg;
  logic req_tgl_reg;
  logic [SYNC_N-1:0] ack_sy_reg;
  logic ack_seen_reg;
  logic busy;
  logic ser_bit;
  logic shifting;
  logic sel_id;
  logic sel_bsr;

  // Core-side signals, all on mclk
  logic [SYNC_N-1:0] req_sy_reg;
  logic req_seen_reg;
  logic ack_tgl_reg;
  logic [1:0] mode_s1_reg;
  logic [1:0] mode_s2_reg;
  logic [1:0] mode_s3_reg;
  logic [1:0] mode_reg;
  logic req_event;
  logic buf_in_ready;
  logic take;

  // Pad keepers report a floating pin; it then reads as one
  assign tms_eff = tms | tms_undriven;
  assign tdi_eff = tdi | tdi_undriven;

  // One decode of the held instruction feeds both the shift path and the output mux
  always_comb begin
    sel_id = 1'b0;
    sel_bsr = 1'b0;
    if (ir_reg == IR_IDCODE) begin
      sel_id = 1'b1;
    end else if (stp_is_bsr(ir_reg)) begin
      sel_bsr = 1'b1;
    end
  end

  // Controller next state, mode select is the only steering input
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: state_next = tms_eff ? ST_RESET : ST_IDLE;
      ST_IDLE: state_next = tms_eff ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_next = tms_eff ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms_eff ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_next = tms_eff ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_next = tms_eff ? ST_UP_DR : ST_PA_DR;
      ST_PA_DR: state_next = tms_eff ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_next = tms_eff ? ST_UP_DR : ST_SH_DR;
      ST_UP_DR: state_next = tms_eff ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_next = tms_eff ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_next = tms_eff ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_next = tms_eff ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_next = tms_eff ? ST_UP_IR : ST_PA_IR;
      ST_PA_IR: state_next = tms_eff ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_next = tms_eff ? ST_UP_IR : ST_SH_IR;
      ST_UP_IR: state_next = tms_eff ? ST_SEL_DR : ST_IDLE;
      default: state_next = ST_RESET;
    endcase
  end

  // Power-on reset is the only asynchronous path; there is no test reset pin
  always_ff @(posedge tck or negedge tap_por_n) begin
    if (!tap_por_n) begin
      state_reg <= ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Instruction shift and hold registers
  always_ff @(posedge tck or negedge tap_por_n) begin
    if (!tap_por_n) begin
      ir_sh_reg <= IR_IDCODE;
      ir_reg <= IR_IDCODE;
    end else begin
      case (state_reg)
        ST_RESET: ir_reg <= IR_IDCODE;
        ST_CAP_IR: ir_sh_reg <= IR_CAPT_VAL;
        ST_SH_IR: ir_sh_reg <= {tdi_eff, ir_sh_reg[IR_W-1:1]};
        ST_UP_IR: ir_reg <= ir_sh_reg;
        default: ir_reg <= ir_reg;
      endcase
    end
  end

  // Data registers; only the one picked by the instruction moves
  always_ff @(posedge tck or negedge tap_por_n) begin
    if (!tap_por_n) begin
      id_sh_reg <= ID_VALUE;
      byp_reg <= 1'b0;
      bsr_sh_reg <= BSR_RST;
    end else if (state_reg == ST_CAP_DR) begin
      if (sel_id) begin
        id_sh_reg <= ID_VALUE;
      end else if (sel_bsr) begin
        bsr_sh_reg <= pad_flt_reg;
      end else begin
        byp_reg <= 1'b0;
      end
    end else if (state_reg == ST_SH_DR) begin
      if (sel_id) begin
        id_sh_reg <= {tdi_eff, id_sh_reg[ID_W-1:1]};
      end else if (sel_bsr) begin
        bsr_sh_reg <= {tdi_eff, bsr_sh_reg[BSR_W-1:1]};
      end else begin
        byp_reg <= tdi_eff;
      end
    end
  end

  // Pads change with the RAM clock; a bit counts once stages two and three agree
  assign pad_diff = pad_s2_reg ^ pad_s3_reg;

  always_ff @(posedge tck or negedge tap_por_n) begin
    if (!tap_por_n) begin
      pad_s1_reg <= BSR_RST;
      pad_s2_reg <= BSR_RST;
      pad_s3_reg <= BSR_RST;
      pad_flt_reg <= BSR_RST;
    end else begin
      pad_s1_reg <= pad_in;
      pad_s2_reg <= pad_s1_reg;
      pad_s3_reg <= pad_s2_reg;
      pad_flt_reg <= (pad_s2_reg & ~pad_diff) | (pad_flt_reg & pad_diff);
    end
  end

  // Mode levels move with the committed instruction, so they settle even when
  // the test clock stops right after Update-IR
  always_ff @(posedge tck or negedge tap_por_n) begin
    if (!tap_por_n) begin
      mode_src_reg <= 2'h0;
    end else if (state_reg == ST_RESET) begin
      mode_src_reg <= 2'h0;
    end else if (state_reg == ST_UP_IR) begin
      mode_src_reg <= {ir_sh_reg == IR_SAMPZ, ir_sh_reg == IR_EXTEST};
    end
  end

  // Update hand-off; a new update while one is in flight is dropped
  assign busy = req_tgl_reg != ack_seen_reg;

  always_ff @(posedge tck or negedge tap_por_n) begin
    if (!tap_por_n) begin
      hold_reg <= UPD_RST;
      req_tgl_reg <= 1'b0;
    end else if (state_reg == ST_UP_DR && stp_is_bsr(ir_reg) && !busy) begin
      hold_reg <= '{samplez: ir_reg == IR_SAMPZ, bits: bsr_sh_reg};
      req_tgl_reg <= !req_tgl_reg;
    end
  end

  always_ff @(posedge tck or negedge tap_por_n) begin
    if (!tap_por_n) begin
      ack_sy_reg <= SYNC_RST;
      ack_seen_reg <= 1'b0;
    end else begin
      ack_sy_reg <= {ack_sy_reg[SYNC_N-2:0], ack_tgl_reg};
      if (ack_sy_reg[1] == ack_sy_reg[2]) begin
        ack_seen_reg <= ack_sy_reg[2];
      end
    end
  end

  // Serial output select by state and instruction
  assign shifting = (state_reg == ST_SH_DR) || (state_reg == ST_SH_IR);

  always_comb begin
    ser_bit = 1'b1;
    if (state_reg == ST_SH_IR) begin
      ser_bit = ir_sh_reg[0];
    end else if (sel_id) begin
      ser_bit = id_sh_reg[0];
    end else if (sel_bsr) begin
      ser_bit = bsr_sh_reg[0];
    end else begin
      ser_bit = byp_reg;
    end
  end

  // Output side moves on the falling edge, half a period after the shift
  always_ff @(negedge tck or negedge tap_por_n) begin
    if (!tap_por_n) begin
      tdo <= 1'b1;
      tdo_oe_n <= 1'b1;
    end else begin
      tdo <= shifting ? ser_bit : 1'b1;
      tdo_oe_n <= !shifting;
    end
  end

  // Core side: request toggle passes three flops before it counts
  assign req_event = (req_sy_reg[1] == req_sy_reg[2]) && (req_sy_reg[2] != req_seen_reg);
  // Held until the buffer has room, which keeps the scan side busy meanwhile
  assign take = req_event && buf_in_ready;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      // Line up with the scan side, so a core reset never replays an old word
      req_sy_reg <= {req_sy_reg[SYNC_N-2:0], req_tgl_reg};
      req_seen_reg <= req_sy_reg[2];
      ack_tgl_reg <= req_sy_reg[2];
    end else begin
      req_sy_reg <= {req_sy_reg[SYNC_N-2:0], req_tgl_reg};
      if (take) begin
        req_seen_reg <= req_sy_reg[2];
        ack_tgl_reg <= req_sy_reg[2];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mode_s1_reg <= 2'h0;
      mode_s2_reg <= 2'h0;
      mode_s3_reg <= 2'h0;
      mode_reg <= 2'h0;
    end else begin
      mode_s1_reg <= mode_src_reg;
      mode_s2_reg <= mode_s1_reg;
      mode_s3_reg <= mode_s2_reg;
      if (mode_s2_reg == mode_s3_reg) begin
        mode_reg <= mode_s3_reg;
      end
    end
  end

  assign extest_mode = mode_reg[0];
  assign samplez_mode = mode_reg[1];

  // The held word is stable while the toggle is in flight
  stp_buf u_buf (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(req_event),
    .in_ready(buf_in_ready),
    .in_data(hold_reg),
    .out_valid(upd_valid),
    .out_ready(upd_ready),
    .out_data(upd_word)
  );

endmodule : stp_tap

// >>> bench/stp_tap_properties.sv
// Checker on the test port pins and the core hand-off
`timescale 1ns/1ps
module stp_tap_properties
  import stp_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic tap_por_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tms_undriven,
  input wire logic tdi,
  input wire logic tdi_undriven,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic [BSR_W-1:0] pad_in,
  input wire logic extest_mode,
  input wire logic samplez_mode,
  input wire logic upd_valid,
  input wire logic upd_ready,
  input stp_upd_s upd_word
);
  // A floating mode pin reads as one
  wire logic t1 = tms | tms_undriven;
  a_word_held: assert property (@(posedge mclk) disable iff (!nrst)
    upd_valid && !upd_ready |=> upd_valid && $stable(upd_word)) else $error("word lost");
  a_core_rst: assert property (@(posedge mclk) !nrst |=> !upd_valid && !extest_mode)
    else $error("core reset ignored");
  a_mode_excl: assert property (@(posedge mclk) disable iff (!nrst)
    !(extest_mode && samplez_mode)) else $error("two modes");
  a_por_idle: assert property (@(posedge mclk) !tap_por_n |-> tdo_oe_n && tdo)
    else $error("tdo active in reset");
  a_tdo_idle: assert property (@(negedge tck) disable iff (!tap_por_n)
    tdo_oe_n |-> tdo) else $error("idle tdo not high");
  a_fall_only: assert property (@(posedge mclk) disable iff (!tap_por_n)
    !$stable({tdo, tdo_oe_n}) |-> !tck) else $error("tdo moved with tck high");
  a_id_first: assert property (@(posedge tck) disable iff (!tap_por_n)
    t1 [*5] ##1 !t1 ##1 t1 ##1 !t1 [*2] |=> !tdo_oe_n && tdo == ID_VALUE[0])
    else $error("first id bit wrong");
  a_ir_capt: assert property (@(posedge tck) disable iff (!tap_por_n)
    t1 [*5] ##1 !t1 ##1 t1 [*2] ##1 !t1 [*2] |=> !tdo_oe_n && tdo)
    else $error("ir capture wrong");
  c_pop: cover property (@(posedge mclk) upd_valid && upd_ready);
  c_stall: cover property (@(posedge mclk) upd_valid && !upd_ready [*4]);
  c_float: cover property (@(posedge tck) tms_undriven && tdi_undriven);
endmodule : stp_tap_properties
bind stp_tap stp_tap_properties u_props (.mclk, .nrst, .tap_por_n, .tck, .tms, .tms_undriven,
  .tdi, .tdi_undriven, .tdo, .tdo_oe_n, .pad_in, .extest_mode, .samplez_mode, .upd_valid,
  .upd_ready, .upd_word);

// >>> bench/stp_jtag_model.sv
// Behavioural scan controller on the far side of the test port
`timescale 1ns/1ps
module stp_jtag_model
  import stp_pkg::*;
(
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic tms_undriven,
  output logic tdi_undriven,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
    tms_undriven = 1'b1;
    tdi_undriven = 1'b1;
  end
  // Pins move while tck is low; a released tdo reads as z so it never passes
  task automatic step(input logic m, input logic d, input logic mf, input logic df,
    output logic q);
    tms <= mf ? ~tms : m;
    tdi <= df ? ~tdi : d;
    tms_undriven <= mf;
    tdi_undriven <= df;
    #40;
    q = tdo_oe_n ? 1'bz : tdo;
    tck <= 1'b1;
    #40;
    tck <= 1'b0;
  endtask : step
  // No reset pin, so five ones on mode select are the only way back
  task automatic tlr(input logic f);
    logic q;
    #3;
    repeat (5) step(1'b1, 1'b0, f, f, q);
    step(1'b0, 1'b0, 1'b0, 1'b0, q);
  endtask : tlr
  task automatic scan(input logic ir, input int n, input logic [31:0] din, input logic df,
    output logic [31:0] dout);
    logic q;
    dout = '0;
    // Gap after a release, so no pin is assigned twice in one time step
    #3;
    step(1'b1, 1'b0, 1'b0, 1'b0, q);
    if (ir) step(1'b1, 1'b0, 1'b0, 1'b0, q);
    repeat (2) step(1'b0, 1'b0, 1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], 1'b0, df, dout[i]);
    end
    step(1'b1, 1'b0, 1'b0, 1'b0, q);
    step(1'b0, 1'b0, 1'b0, 1'b0, q);
    tms_undriven <= 1'b1;
    tdi_undriven <= 1'b1;
    tdi <= ~tdi;
  endtask : scan
endmodule : stp_jtag_model

// >>> bench/stp_tap_bench.sv
// Self-checking bench for the test port and its core hand-off
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module stp_tap_bench
  import stp_pkg::*;
;
  localparam logic [2:0] CODES [6] = '{IR_EXTEST, IR_IDCODE, IR_SAMPZ, IR_SAMPLE,
    IR_BYPASS, 3'h3};
  logic mclk, nrst, tap_por_n, tck, tms, tms_undriven, tdi, tdi_undriven, tdo, tdo_oe_n;
  logic extest_mode, samplez_mode, upd_valid, upd_ready, rdy_en, tf;
  logic [BSR_W-1:0] pad_in, eff;
  logic [31:0] din, dout;
  logic [2:0] c;
  stp_upd_s upd_word, exp_w;
  stp_upd_s exp_q[$];
  int errors, tests_run, seed;
  stp_tap u_dut (.mclk, .nrst, .tap_por_n, .tck, .tms, .tms_undriven, .tdi, .tdi_undriven,
    .tdo, .tdo_oe_n, .pad_in, .extest_mode, .samplez_mode, .upd_valid, .upd_ready, .upd_word);
  stp_jtag_model u_jtag (.tck, .tms, .tdi, .tms_undriven, .tdi_undriven, .tdo, .tdo_oe_n);
  always #5 mclk = ~mclk;
  always @(posedge mclk) upd_ready <= rdy_en && ($random(seed) & 1);
  always @(posedge mclk) begin
    if (upd_valid === 1'b1 && upd_ready === 1'b1) begin
      if (exp_q.size() == 0) `CHK(upd_valid, 1'b0)
      else begin
        exp_w = exp_q.pop_front();
        `CHK(upd_word, exp_w)
      end
    end
  end
  // Unmapped codes fall back to the one-bit bypass, which captures zero
  function automatic logic [7:0] exp_dr(input logic [2:0] k, input logic [7:0] d);
    if (k == IR_IDCODE) return ID_VALUE[7:0];
    if (k == IR_EXTEST || k == IR_SAMPZ || k == IR_SAMPLE) return pad_in;
    return {d[6:0], 1'b0};
  endfunction : exp_dr
  task automatic finish_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    #400us;
    errors++;
    finish_test();
  end
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    tap_por_n = 1'b1;
    pad_in = '0;
    upd_ready = 1'b0;
    rdy_en = 1'b0;
    errors = 0;
    tests_run = 0;
    seed = 32'h0166;
    // Power-on reset falls on an edge, so it cannot race the flops at time zero
    @(posedge mclk);
    tap_por_n <= 1'b0;
    repeat (19) @(posedge mclk);
    `CHK({tdo, tdo_oe_n, upd_valid, extest_mode}, 4'hC)
    nrst <= 1'b1;
    tap_por_n <= 1'b1;
    repeat (2000) @(posedge mclk);
    `CHK({tdo_oe_n, upd_valid, extest_mode, samplez_mode}, 4'h8)
    u_jtag.tlr(1'b1);
    din = $random(seed);
    u_jtag.scan(1'b0, 32, din, 1'b0, dout);
    `CHK(dout, ID_VALUE)
    for (int k = 0; k < 16; k++) begin
      c = (k < 6) ? CODES[k] : 3'($random(seed));
      @(posedge mclk);
      rdy_en <= 1'b1;
      pad_in <= 8'($random(seed));
      din = $random(seed);
      u_jtag.tlr(k[0]);
      u_jtag.scan(1'b1, 3, {29'h0, c}, 1'b0, dout);
      `CHK(dout[2:0], IR_CAPT_VAL)
      repeat (10) @(posedge mclk);
      `CHK({extest_mode, samplez_mode}, {c == IR_EXTEST, c == IR_SAMPZ})
      tf = (k % 5 == 0);
      eff = tf ? 8'hFF : din[7:0];
      if (c == IR_EXTEST || c == IR_SAMPZ || c == IR_SAMPLE)
        exp_q.push_back(stp_upd_s'{c == IR_SAMPZ, eff});
      u_jtag.scan(1'b0, 8, din, tf, dout);
      `CHK(dout[7:0], exp_dr(c, eff))
    end
    for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge mclk);
    rdy_en <= 1'b0;
    u_jtag.scan(1'b1, 3, {29'h0, IR_SAMPLE}, 1'b0, dout);
    for (int i = 0; i < 2; i++) begin
      din = $random(seed);
      exp_q.push_back(stp_upd_s'{1'b0, din[7:0]});
      u_jtag.scan(1'b0, 8, din, 1'b0, dout);
    end
    repeat (30) @(posedge mclk);
    `CHK({upd_valid, exp_q.size() == 2}, 2'h3)
    rdy_en <= 1'b1;
    repeat (60) @(posedge mclk);
    `CHK({upd_valid, exp_q.size() == 0}, 2'h1)
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (30) @(posedge mclk);
    `CHK({upd_valid, exp_q.size() == 0}, 2'h1)
    finish_test();
  end
endmodule : stp_tap_bench
